// ==== store_pkg.sv ====
// Shared constants and carrier types for the store execution block.
package store_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction field positions, counted from the least significant bit.
   localparam int PRIM_MSB = 31;
   localparam int PRIM_LSB = 26;
   localparam int SRC_MSB = 25;
   localparam int SRC_LSB = 21;
   localparam int BASE_MSB = 20;
   localparam int BASE_LSB = 16;
   localparam int INDEX_MSB = 15;
   localparam int INDEX_LSB = 11;
   localparam int XO_MSB = 10;
   localparam int XO_LSB = 1;
   localparam int DISP_MSB = 15;
   localparam int DISP_LSB = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Opcodes.
   localparam logic [5:0] OP_INDEXED = 6'h1f;
   localparam logic [5:0] OP_HALF = 6'h2c;
   localparam logic [5:0] OP_HALF_UPD = 6'h2d;
   localparam logic [9:0] XO_FP_SINGLE = 10'h297;
   localparam logic [9:0] XO_HALF_IDX = 10'h197;
   localparam logic [9:0] XO_HALF_UPD_IDX = 10'h1b7;
   localparam logic [9:0] XO_HALF_SWAP = 10'h396;

   ////////////////////////////////////////////////////////////////////////////
   // Store sizes, single-precision packing limits and the zero register number.
   localparam logic [1:0] SIZE_NONE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [10:0] FP_NORM_LIMIT = 11'h380;
   localparam logic [10:0] FP_NORM_MIN_EXP = 11'h381;
   localparam logic [10:0] FP_DENORM_MIN_EXP = 11'h36a;
   localparam logic [4:0] REG_ZERO = 5'h00;

   typedef struct packed {
      logic [31:0] instr;
      logic [31:0] base_val;
      logic [31:0] index_val;
      logic [31:0] src_val;
      logic [63:0] fpr_val;
   } op_in_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [1:0] size;
      logic [31:0] data;
   } store_req_t;

   typedef struct packed {
      logic [4:0] reg_idx;
      logic [31:0] value;
   } reg_wb_t;

endpackage

// ==== fp_single_pack.sv ====
// Packs a double-precision register image into a single-precision storage word.
`timescale 1ns/10ps
module fp_single_pack
   import store_pkg::*;
(
   input wire logic [63:0] double_i,
   output logic [31:0] single_o
);

   logic [10:0] exp_field;
   logic [10:0] exp_gap;
   logic [23:0] frac;

   // Rounding is not modelled: in-range values are truncated, as the store
   // path only moves bits and never touches the status register.
   always_comb begin
      exp_field = double_i[62:52];
      exp_gap = FP_NORM_MIN_EXP - exp_field;
      frac = {1'b1, double_i[51:29]} >> exp_gap[4:0];
      if (exp_field > FP_NORM_LIMIT || exp_field == 11'h000) begin
         single_o = {double_i[63:62], double_i[58:29]};
      end else if (exp_field >= FP_DENORM_MIN_EXP) begin
         single_o = {double_i[63], 8'h00, frac[22:0]};
      end else begin
         single_o = {double_i[63:62], double_i[58:29]};
      end
   end

endmodule

// ==== store_half_single_exec.sv ====
// Decode and execution of the single-precision indexed and halfword store group.
`timescale 1ns/10ps
module store_half_single_exec
   import store_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic op_valid_i,
   input wire op_in_t op_i,
   input wire logic store_ack_i,
   input wire logic align_fault_i,
   input wire logic dsi_fault_i,
   output logic op_ready_o,
   output logic store_valid_o,
   output store_req_t store_o,
   output logic wb_valid_o,
   output reg_wb_t wb_o,
   output logic unsupported_o
);

   typedef enum logic {ST_IDLE, ST_STORE} state_t;

   function automatic logic [5:0] prim_of(input logic [31:0] instr);
      prim_of = instr[PRIM_MSB:PRIM_LSB];
   endfunction

   function automatic logic [9:0] xo_of(input logic [31:0] instr);
      xo_of = instr[XO_MSB:XO_LSB];
   endfunction

   function automatic logic [4:0] base_of(input logic [31:0] instr);
      base_of = instr[BASE_MSB:BASE_LSB];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Decode.
   logic [5:0] prim;
   logic [9:0] xo;
   logic [4:0] base_reg_field;
   logic [31:0] disp_ext;
   logic [31:0] idx_ea;
   logic [31:0] disp_ea;
   logic is_fp;
   logic is_half_disp;
   logic is_half_idx;
   logic is_swap;
   logic is_update;
   logic supported;
   logic accept;
   logic [31:0] fp_word;

   fp_single_pack u_pack (
      .double_i(op_i.fpr_val),
      .single_o(fp_word)
   );

   // Bit 0 of an indexed word is never looked at, so indexed forms decode either way.
   always_comb begin
      prim = prim_of(op_i.instr);
      xo = xo_of(op_i.instr);
      base_reg_field = base_of(op_i.instr);
      disp_ext = {{16{op_i.instr[DISP_MSB]}}, op_i.instr[DISP_MSB:DISP_LSB]};
      idx_ea = (base_reg_field != REG_ZERO) ? op_i.base_val + op_i.index_val
                                            : op_i.index_val;
      disp_ea = (base_reg_field != REG_ZERO) ? op_i.base_val + disp_ext : disp_ext;
      is_fp = prim == OP_INDEXED && xo == XO_FP_SINGLE;
      is_swap = prim == OP_INDEXED && xo == XO_HALF_SWAP;
      is_half_idx = prim == OP_INDEXED && (xo == XO_HALF_IDX || xo == XO_HALF_UPD_IDX);
      is_half_disp = prim == OP_HALF || prim == OP_HALF_UPD;
      is_update = prim == OP_HALF_UPD || (prim == OP_INDEXED && xo == XO_HALF_UPD_IDX);
      supported = is_fp || is_swap || is_half_idx || is_half_disp;
      accept = op_valid_i && op_ready_o;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencing: one store in flight, then an optional base write-back.
   state_t state;
   state_t next_state;
   logic next_op_ready;
   logic next_store_valid;
   store_req_t next_store;
   logic next_wb_valid;
   reg_wb_t next_wb;
   logic next_unsupported;
   logic upd_pending;
   logic next_upd_pending;
   logic [4:0] upd_reg;
   logic [4:0] next_upd_reg;

   always_comb begin
      next_state = state;
      next_op_ready = op_ready_o;
      next_store_valid = store_valid_o;
      next_store = store_o;
      next_wb_valid = 1'b0;
      next_wb = wb_o;
      next_unsupported = 1'b0;
      next_upd_pending = upd_pending;
      next_upd_reg = upd_reg;
      case (state)
         ST_IDLE: begin
            if (accept && supported) begin
               next_state = ST_STORE;
               next_op_ready = 1'b0;
               next_store_valid = 1'b1;
               next_store.addr = is_half_disp ? disp_ea : idx_ea;
               if (is_fp) begin
                  next_store.size = SIZE_WORD;
                  next_store.data = fp_word;
               end else if (is_swap) begin
                  next_store.size = SIZE_HALF;
                  next_store.data = {16'h0000, op_i.src_val[7:0], op_i.src_val[15:8]};
               end else begin
                  next_store.size = SIZE_HALF;
                  next_store.data = {16'h0000, op_i.src_val[15:0]};
               end
               // Only update forms with a nonzero base ever arm the write-back.
               next_upd_pending = is_update && base_reg_field != REG_ZERO;
               next_upd_reg = base_reg_field;
            end else if (accept) begin
               next_unsupported = 1'b1;
            end
         end
         ST_STORE: begin
            if (store_ack_i) begin
               next_state = ST_IDLE;
               next_op_ready = 1'b1;
               next_store_valid = 1'b0;
               next_upd_pending = 1'b0;
               // A faulting access must leave the base register as it was.
               if (upd_pending && !align_fault_i && !dsi_fault_i) begin
                  next_wb_valid = 1'b1;
                  next_wb.reg_idx = upd_reg;
                  next_wb.value = store_o.addr;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_op_ready = 1'b1;
            next_store_valid = 1'b0;
            next_upd_pending = 1'b0;
         end
      endcase
   end

   // No status, exception or condition outputs exist: the only register the
   // block can change is the base register through the write-back port.
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         state <= ST_IDLE;
         op_ready_o <= 1'b1;
         store_valid_o <= 1'b0;
         store_o <= '0;
         wb_valid_o <= 1'b0;
         wb_o <= '0;
         unsupported_o <= 1'b0;
         upd_pending <= 1'b0;
         upd_reg <= REG_ZERO;
      end else begin
         state <= next_state;
         op_ready_o <= next_op_ready;
         store_valid_o <= next_store_valid;
         store_o <= next_store;
         wb_valid_o <= next_wb_valid;
         wb_o <= next_wb;
         unsupported_o <= next_unsupported;
         upd_pending <= next_upd_pending;
         upd_reg <= next_upd_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   a_fp_word: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      accept && prim_of(op_i.instr) == OP_INDEXED && xo_of(op_i.instr) == XO_FP_SINGLE
      |=> store_valid_o && store_o.size == SIZE_WORD && store_o.data == $past(fp_word))
      else $error("single store word wrong");

   a_index_ea: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      accept && prim_of(op_i.instr) == OP_INDEXED && supported
      |=> store_o.addr == ($past(base_of(op_i.instr)) != REG_ZERO
          ? $past(op_i.base_val) + $past(op_i.index_val) : $past(op_i.index_val)))
      else $error("indexed address wrong");

   a_disp_ea: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      accept && (prim_of(op_i.instr) == OP_HALF || prim_of(op_i.instr) == OP_HALF_UPD)
      |=> store_o.addr == ($past(base_of(op_i.instr)) != REG_ZERO
          ? $past(op_i.base_val) + {{16{$past(op_i.instr[15])}}, $past(op_i.instr[15:0])}
          : {{16{$past(op_i.instr[15])}}, $past(op_i.instr[15:0])}))
      else $error("displacement address wrong");

   a_half_data: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      accept && (prim_of(op_i.instr) == OP_HALF || is_half_idx)
      |=> store_o.size == SIZE_HALF && store_o.data == {16'h0000, $past(op_i.src_val[15:0])})
      else $error("halfword data wrong");

   a_swap_data: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      accept && is_swap
      |=> store_o.data[15:8] == $past(op_i.src_val[7:0])
          && store_o.data[7:0] == $past(op_i.src_val[15:8]) && store_o.size == SIZE_HALF)
      else $error("byte-reversed data wrong");

   a_update_arm: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      accept && is_update && base_of(op_i.instr) != REG_ZERO
      |=> upd_pending && upd_reg == $past(base_of(op_i.instr)))
      else $error("update not armed");

   a_update_wb: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      store_valid_o && store_ack_i && upd_pending && !align_fault_i && !dsi_fault_i
      |=> wb_valid_o && wb_o.value == $past(store_o.addr) && wb_o.reg_idx == $past(upd_reg))
      else $error("update write-back wrong");

   a_wb_cause: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      wb_valid_o |-> $past(store_valid_o && store_ack_i && upd_pending
                           && !align_fault_i && !dsi_fault_i))
      else $error("write-back without faultless update");

   a_no_update: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      accept && supported && !(is_update && base_of(op_i.instr) != REG_ZERO)
      |=> !upd_pending ##1 !wb_valid_o)
      else $error("base updated by non-update store");

   a_wb_target: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      wb_valid_o |-> wb_o.reg_idx != REG_ZERO && !store_valid_o)
      else $error("write-back target wrong");

   a_bit_ignored: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      accept && prim_of(op_i.instr) == OP_INDEXED && (xo_of(op_i.instr) == XO_HALF_IDX
         || xo_of(op_i.instr) == XO_FP_SINGLE || xo_of(op_i.instr) == XO_HALF_SWAP)
      |=> store_valid_o && !unsupported_o)
      else $error("indexed form refused");

endmodule

// ==== mem_store_model.sv ====
// Behavioural data-memory store responder with programmable delay and faults.
`timescale 1ns/10ps
module mem_store_model (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic store_valid_i,
   input wire logic [1:0] delay_i,
   input wire logic align_i,
   input wire logic dsi_i,
   output logic store_ack_o,
   output logic align_fault_o,
   output logic dsi_fault_o
);
   logic [1:0] wait_cnt;
   logic tog;
   // Faults toggle outside the ack cycle, so sampling them at the wrong time shows up.
   assign align_fault_o = store_ack_o ? align_i : tog;
   assign dsi_fault_o = store_ack_o ? dsi_i : ~tog;
   always_ff @(posedge clock_i) begin
      tog <= reset_n_i ? ~tog : 1'b0;
      if (!reset_n_i || store_ack_o) begin
         wait_cnt <= 2'h0;
         store_ack_o <= 1'b0;
      end else if (store_valid_i) begin
         if (wait_cnt == delay_i) begin
            store_ack_o <= 1'b1;
         end else begin
            wait_cnt <= wait_cnt + 2'h1;
         end
      end
   end
endmodule

// ==== tb_top.sv ====
// Self-checking testbench for the store execution block.
`timescale 1ns/10ps
module tb_top;
   import store_pkg::*;
   logic clock_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic op_valid_i = 1'b0;
   op_in_t op_i = '0;
   logic store_ack_i, align_fault_i, dsi_fault_i;
   logic op_ready_o, store_valid_o, wb_valid_o, unsupported_o;
   store_req_t store_o;
   reg_wb_t wb_o;
   logic [1:0] delay = 2'h0;
   logic al = 1'b0;
   logic ds = 1'b0;
   int n_mismatch = 0;
   int cmp_count = 0;
   // Kinds 6 and 7 lie outside the group and must be dropped.
   logic [5:0] prim_tab [8] = '{OP_INDEXED, OP_HALF, OP_INDEXED, OP_HALF_UPD,
      OP_INDEXED, OP_INDEXED, 6'h34, OP_INDEXED};
   logic [9:0] xo_tab [8] = '{XO_FP_SINGLE, 10'h0, XO_HALF_SWAP, 10'h0,
      XO_HALF_UPD_IDX, XO_HALF_IDX, 10'h0, 10'h2b7};

   always #10 clock_i = ~clock_i;

   store_half_single_exec i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .op_valid_i(op_valid_i), .op_i(op_i), .store_ack_i(store_ack_i),
      .align_fault_i(align_fault_i), .dsi_fault_i(dsi_fault_i), .op_ready_o(op_ready_o),
      .store_valid_o(store_valid_o), .store_o(store_o), .wb_valid_o(wb_valid_o),
      .wb_o(wb_o), .unsupported_o(unsupported_o));

   mem_store_model i_mem (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .store_valid_i(store_valid_o), .delay_i(delay), .align_i(al), .dsi_i(ds),
      .store_ack_o(store_ack_i), .align_fault_o(align_fault_i), .dsi_fault_o(dsi_fault_i));

   ////////////////////////////////////////
   task automatic note(string w, logic [65:0] e, logic [65:0] s);
      cmp_count++;
      if (e !== s) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic chk_bit(string w, logic e, logic s);
      note(w, 66'(e), 66'(s));
   endtask
   task automatic chk_st(string w, store_req_t e, store_req_t s);
      note(w, 66'(e), 66'(s));
   endtask
   task automatic chk_wb(string w, reg_wb_t e, reg_wb_t s);
      note(w, 66'(e), 66'(s));
   endtask

   task automatic end_sim();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Truncating conversion; rounding is deliberately not modelled.
   function automatic logic [31:0] to_single(logic [63:0] d);
      int e;
      e = d[62:52];
      if (e > 896 || e < 874) return {d[63:62], d[58:29]};
      return {d[63], 8'h00, 23'({1'b1, d[51:29]} >> (897 - e))};
   endfunction

   ////////////////////////////////////////
   task automatic run_op(int k, logic [4:0] b, logic [63:0] fp, logic [31:0] bv,
      logic [31:0] xv);
      logic [31:0] ins, src, ea;
      store_req_t ex;
      logic upd;
      int n;
      src = $urandom;
      ins = {prim_tab[k], 5'($urandom), b, 16'($urandom)};
      if (prim_tab[k] == OP_INDEXED) ins[10:1] = xo_tab[k];
      ea = (prim_tab[k] == OP_INDEXED) ? xv : {{16{ins[15]}}, ins[15:0]};
      if (b != REG_ZERO) ea = ea + bv;
      ex.addr = ea;
      ex.size = (k == 0) ? SIZE_WORD : SIZE_HALF;
      ex.data = (k == 0) ? to_single(fp) : (k == 2) ? {16'h0, src[7:0], src[15:8]} :
         {16'h0, src[15:0]};
      upd = (k == 3 || k == 4) && b != REG_ZERO && !al && !ds;
      chk_bit("op_ready", 1'b1, op_ready_o);
      op_i = '{ins, bv, xv, src, fp};
      op_valid_i = 1'b1;
      @(posedge clock_i);
      #1;
      // The request is replaced by the next call, or the run ends, in this time step.
      if (k > 5) begin
         chk_bit("unsupported", 1'b1, unsupported_o);
         chk_bit("store_valid", 1'b0, store_valid_o);
         return;
      end
      chk_st("store", ex, store_o);
      chk_bit("unsupported", 1'b0, unsupported_o);
      // Requests offered while busy must be ignored.
      for (n = 0; n < 20 && !store_ack_i; n++) begin
         op_valid_i = 1'($urandom);
         op_i.instr = $urandom;
         @(posedge clock_i);
         #1;
         chk_bit("op_ready", 1'b0, op_ready_o);
      end
      chk_bit("ack_wait", 1'b1, store_ack_i);
      chk_st("store_held", ex, store_o);
      @(posedge clock_i);
      #1;
      chk_bit("store_valid", 1'b0, store_valid_o);
      chk_bit("wb_valid", upd, wb_valid_o);
      if (upd) chk_wb("wb", '{b, ea}, wb_o);
   endtask

   initial begin
      int k;
      logic [4:0] b;
      void'($urandom(32'h97b90e6b));
      repeat (4) @(posedge clock_i);
      #1;
      reset_n_i = 1'b1;
      chk_st("store_rst", '0, store_o);
      chk_wb("wb_rst", '0, wb_o);
      run_op(0, 5'h0, 64'h48656c6c6f20776f, $urandom, 32'h100);
      chk_st("store_example", '{32'h0000_0100, SIZE_WORD, 32'h432b_6363}, store_o);
      run_op(0, 5'h3, {1'b1, 11'h370, 52'h5a5a5a5a5a5a5}, $urandom, $urandom);
      repeat (400) begin
         k = $urandom_range(7);
         b = ($urandom_range(3) == 0) ? 5'h0 : 5'($urandom);
         al = ($urandom_range(5) == 0);
         ds = ($urandom_range(5) == 0);
         delay = 2'($urandom);
         run_op(k, b, {$urandom, $urandom}, $urandom, $urandom);
      end
      end_sim();
   end

   initial begin
      #600000;
      $display("watchdog expired");
      n_mismatch++;
      end_sim();
   end
endmodule
